// ===== src/loadable_counter_with_input_register.sv
// 8-bit holding register feeding an 8-bit loadable binary up counter
// assumes all pin inputs are asynchronous to clk and pass the synchroniser first;
// the two pin clocks are slow against clk and are used as sampled edges
//
// Function
// R1 - each rising edge of the holding register clock captures the eight data inputs into the holding register.
// R2 - the counter advances on rising edges of its own clock, independent of the holding register clock.
// R3 - while the load input is low the holding register value is copied into the counter without a clock edge.
// R4 - while the clear input is low the counter is forced to zero, above load and count.
// R5 - the counter advances on a counter clock edge only while the count enable is low, otherwise it holds.
// R6 - an active-low ripple carry output is provided to drive the count enable of a following stage.
// R7 - in the shared-pin variant the same pins feed the holding register and drive the counter value when enabled.
// R8 - the user raises the holding register clock before the counter clock so that the counter sees settled data.
// R9 - ripple carry is low while the counter holds all ones, and an enabled count from all ones wraps to zero.
// R10 - the shared pins are driven only while the high enable is high and the low enable is low.
`timescale 1ns/10ps
`include "loadable_counter_cfg.svh"

module loadable_counter_with_input_register (
  input wire logic clk,
  input wire logic reset_n,
  input wire loadable_counter_pkg::count_t data_in,
  input wire loadable_counter_pkg::count_t shared_pins_in,
  output loadable_counter_pkg::count_t shared_pins_out,
  output logic shared_pins_oe,
  input wire logic shared_pin_mode,
  input wire logic holding_register_clock,
  input wire logic counter_clock,
  input wire logic counter_clear_n,
  input wire logic counter_load_n,
  input wire logic count_enable_n,
  input wire logic output_enable,
  input wire logic output_enable_n,
  output loadable_counter_pkg::count_t counter_value,
  output loadable_counter_pkg::count_t holding_value,
  output logic ripple_carry_out_n
);

  import loadable_counter_pkg::*;

  logic [`SYNC_BITS-1:0] pins_raw;
  logic [`SYNC_BITS-1:0] pins_sync;
  count_t data_sync;
  count_t bus_sync;
  logic reg_clk_sync;
  logic cnt_clk_sync;
  logic clear_n_sync;
  logic load_n_sync;
  logic enable_n_sync;
  logic oe_sync;
  logic oe_n_sync;
  logic shared_sync;
  logic reg_clk_prev_reg;
  logic reg_clk_prev_next;
  logic cnt_clk_prev_reg;
  logic cnt_clk_prev_next;
  logic reg_clk_rise;
  logic cnt_clk_rise;
  count_t capture_src;
  count_t hold_reg;
  count_t hold_next;
  count_t count_reg;
  count_t count_next;
  count_action_t action;
  logic carry_n_reg;
  logic carry_n_next;
  logic drive_reg;
  logic drive_next;

  // gather every pin input into one vector for the synchroniser
  assign pins_raw = {shared_pin_mode, output_enable_n, output_enable, count_enable_n,
                     counter_load_n, counter_clear_n, counter_clock, holding_register_clock,
                     shared_pins_in, data_in};

  pin_sync #(
    .WIDTH(`SYNC_BITS),
    .RESET_VAL(`SYNC_RESET)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // split the synchronised vector back into named signals
  assign data_sync = pins_sync[`PIN_DATA_MSB:`PIN_DATA_LSB];
  assign bus_sync = pins_sync[`PIN_BUS_MSB:`PIN_BUS_LSB];
  assign reg_clk_sync = pins_sync[`PIN_REG_CLK];
  assign cnt_clk_sync = pins_sync[`PIN_CNT_CLK];
  assign clear_n_sync = pins_sync[`PIN_CLR_N];
  assign load_n_sync = pins_sync[`PIN_LOAD_N];
  assign enable_n_sync = pins_sync[`PIN_EN_N];
  assign oe_sync = pins_sync[`PIN_OE];
  assign oe_n_sync = pins_sync[`PIN_OE_N];
  assign shared_sync = pins_sync[`PIN_SHARED];

  // rising edges of the two pin clocks, seen after synchronisation
  assign reg_clk_rise = reg_clk_sync && !reg_clk_prev_reg;
  assign cnt_clk_rise = cnt_clk_sync && !cnt_clk_prev_reg;

  // in shared-pin mode the pins themselves feed the holding register
  assign capture_src = shared_sync ? bus_sync : data_sync; // R7

  // counter action, clear above load above count
  always_comb
  begin
    if (!clear_n_sync)
    begin
      action = ACT_CLEAR; // R4
    end
    else if (!load_n_sync)
    begin
      action = ACT_LOAD; // R3
    end
    else if (cnt_clk_rise && !enable_n_sync)
    begin
      action = ACT_COUNT; // R2 R5
    end
    else
    begin
      action = ACT_HOLD; // R5
    end
  end

  // next values of edge history, holding register, counter and outputs
  always_comb
  begin
    reg_clk_prev_next = reg_clk_sync;
    cnt_clk_prev_next = cnt_clk_sync;
    hold_next = hold_reg;
    if (reg_clk_rise)
    begin
      hold_next = capture_src; // R1
    end
    case (action)
      ACT_CLEAR: count_next = `CNT_ZERO; // R4
      ACT_LOAD: count_next = hold_reg; // R3
      ACT_COUNT: count_next = count_reg + `CNT_ONE; // R2 R9
      default: count_next = count_reg;
    endcase
    carry_n_next = (count_next != `CNT_ALL_ONES); // R6 R9
    drive_next = shared_sync && oe_sync && !oe_n_sync; // R10
    if (!reset_n)
    begin
      reg_clk_prev_next = 1'b0;
      cnt_clk_prev_next = 1'b0;
      hold_next = `HOLD_RESET;
      count_next = `CNT_ZERO;
      carry_n_next = 1'b1;
      drive_next = 1'b0;
    end
  end

  // register all state
  always_ff @(posedge clk)
  begin
    reg_clk_prev_reg <= reg_clk_prev_next;
    cnt_clk_prev_reg <= cnt_clk_prev_next;
    hold_reg <= hold_next;
    count_reg <= count_next;
    carry_n_reg <= carry_n_next;
    drive_reg <= drive_next;
  end

  // outputs straight from flip-flops
  assign counter_value = count_reg;
  assign holding_value = hold_reg;
  assign ripple_carry_out_n = carry_n_reg; // R6
  assign shared_pins_out = count_reg; // R7
  assign shared_pins_oe = drive_reg; // R10

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // a register clock edge stores the selected pins
  chk_hold_capture: assert property (reg_clk_rise |=> hold_reg == $past(capture_src)) // R1
    else $error("holding register missed a capture");

  // an enabled count edge adds exactly one
  chk_count_step: assert property (
    clear_n_sync && load_n_sync && cnt_clk_rise && !enable_n_sync
    |=> count_reg == $past(count_reg) + `CNT_ONE) // R2
    else $error("counter did not advance by one");

  // load copies the holding register without a counter edge
  chk_load_copy: assert property (clear_n_sync && !load_n_sync |=> count_reg == $past(hold_reg)) // R3
    else $error("load did not copy the holding register");

  // clear forces zero whatever load and count do
  chk_clear_wins: assert property (!clear_n_sync |=> count_reg == `CNT_ZERO ##1 1'b1) // R4
    else $error("clear did not force zero");

  // no enabled edge means the count stands
  chk_count_hold: assert property (
    clear_n_sync && load_n_sync && !(cnt_clk_rise && !enable_n_sync) |=> $stable(count_reg)) // R5
    else $error("counter changed without an enabled edge");

  // carry output follows all ones on the counter
  chk_carry_flag: assert property (ripple_carry_out_n == (counter_value != `CNT_ALL_ONES)) // R6
    else $error("ripple carry does not match counter");

  // enabled count from all ones wraps and releases the carry
  chk_wrap_zero: assert property (
    count_reg == `CNT_ALL_ONES && clear_n_sync && load_n_sync && cnt_clk_rise && !enable_n_sync
    |=> count_reg == `CNT_ZERO && ripple_carry_out_n) // R9
    else $error("counter did not wrap from all ones");

  // in shared-pin mode a register clock edge stores the pin levels, not the plain inputs
  chk_pin_capture: assert property (reg_clk_rise && shared_sync |=> hold_reg == $past(bus_sync)) // R7
    else $error("holding register missed the shared pins");

  // in plain mode a register clock edge stores the plain data inputs
  chk_plain_capture: assert property (reg_clk_rise && !shared_sync |=> hold_reg == $past(data_sync)) // R1
    else $error("holding register missed the data inputs");

  // pin drive follows the two enables one cycle later
  chk_oe_gate: assert property (
    (shared_sync && oe_sync && !oe_n_sync) |=> shared_pins_oe ##1 1'b1) // R10
    else $error("shared pins not driven when enabled");

  // any other enable pair or plain mode releases the pins one cycle later
  chk_oe_off: assert property (!(shared_sync && oe_sync && !oe_n_sync) |=> !shared_pins_oe) // R10
    else $error("shared pins driven while disabled");

endmodule // loadable_counter_with_input_register

// ===== src/loadable_counter_cfg.svh
// constants for the loadable counter with input holding register
// assumes inclusion by bare name from the package and the design files
`ifndef LOADABLE_COUNTER_CFG_SVH
`define LOADABLE_COUNTER_CFG_SVH

// counter and holding register width and key values
`define CNT_WIDTH 8
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01
`define CNT_ALL_ONES 8'hFF
`define HOLD_RESET 8'h00

// positions of the pin inputs inside the synchroniser vector
`define SYNC_BITS 24
`define PIN_DATA_LSB 0
`define PIN_DATA_MSB 7
`define PIN_BUS_LSB 8
`define PIN_BUS_MSB 15
`define PIN_REG_CLK 16
`define PIN_CNT_CLK 17
`define PIN_CLR_N 18
`define PIN_LOAD_N 19
`define PIN_EN_N 20
`define PIN_OE 21
`define PIN_OE_N 22
`define PIN_SHARED 23

// synchroniser reset value: active-low controls rest at their inactive level
`define SYNC_RESET 24'h5C0000

`endif

// ===== src/loadable_counter_pkg.sv
// types shared by the loadable counter design files
// assumes the constants header is on the include path
`include "loadable_counter_cfg.svh"

package loadable_counter_pkg;

  // counter and holding register word
  typedef logic [`CNT_WIDTH-1:0] count_t;

  // action taken on the counter in one cycle, in priority order from low
  typedef enum logic [1:0]
  {
    ACT_HOLD = 2'b00,
    ACT_COUNT = 2'b01,
    ACT_LOAD = 2'b10,
    ACT_CLEAR = 2'b11
  } count_action_t;

endpackage

// ===== src/pin_sync.sv
// two-stage synchroniser for a vector of pin inputs
// assumes every bit is asynchronous to clk; each bit crosses on its own
`timescale 1ns/10ps

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage2_next;

  // first stage is read only by the second stage
  always_comb
  begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
    if (!reset_n)
    begin
      stage1_next = RESET_VAL;
      stage2_next = RESET_VAL;
    end
  end

  // register both stages
  always_ff @(posedge clk)
  begin
    stage1_reg <= stage1_next;
    stage2_reg <= stage2_next;
  end

  assign sync_out = stage2_reg;

endmodule // pin_sync

// ===== dv/shared_pin_model.sv
// far-side model of the shared three-state pins and their wire level
// assumes at most one party drives the pins at a time
`timescale 1ns/10ps

module shared_pin_model (
  input wire logic clk,
  input wire loadable_counter_pkg::count_t dut_out,
  input wire logic dut_oe,
  input wire loadable_counter_pkg::count_t ext_data,
  input wire logic ext_oe,
  output loadable_counter_pkg::count_t level
);
  import loadable_counter_pkg::*;
  count_t last_reg = 8'h00;

  // released pins show a changing pattern, never a stale copy
  always_comb
  begin
    if (dut_oe)
      level = dut_out;
    else if (ext_oe)
      level = ext_data;
    else
      level = ~last_reg;
  end

  // remember the last wire level
  always_ff @(posedge clk)
    last_reg <= level;
endmodule // shared_pin_model

// ===== dv/loadable_counter_with_input_register_tb_top.sv
// testbench for the loadable counter with input holding register
// assumes pin changes reach the outputs within three clocks; each wait allows four
`timescale 1ns/10ps

module loadable_counter_with_input_register_tb_top;
  import loadable_counter_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  count_t data_in = 8'h00;
  count_t ext_data = 8'h00;
  logic ext_oe = 1'b0;
  count_t pins_level;
  count_t pins_out;
  logic pins_oe;
  logic mode = 1'b0;
  logic reg_clk_pin = 1'b0;
  logic cnt_clk_pin = 1'b0;
  logic clr_n = 1'b1;
  logic load_n = 1'b1;
  logic en_n = 1'b1;
  logic oe = 1'b0;
  logic oe_n = 1'b1;
  count_t cnt;
  count_t hold;
  logic carry_n;
  int err_count = 0;
  int compares = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  loadable_counter_with_input_register u_dut (
    .clk(clk), .reset_n(reset_n), .data_in(data_in), .shared_pins_in(pins_level),
    .shared_pins_out(pins_out), .shared_pins_oe(pins_oe), .shared_pin_mode(mode),
    .holding_register_clock(reg_clk_pin), .counter_clock(cnt_clk_pin), .counter_clear_n(clr_n),
    .counter_load_n(load_n), .count_enable_n(en_n), .output_enable(oe), .output_enable_n(oe_n),
    .counter_value(cnt), .holding_value(hold), .ripple_carry_out_n(carry_n)
  );

  shared_pin_model u_pins (
    .clk(clk), .dut_out(pins_out), .dut_oe(pins_oe), .ext_data(ext_data), .ext_oe(ext_oe),
    .level(pins_level)
  );

  // compare and count
  task automatic check(input string name, input count_t seen, input count_t exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // let a pin change pass the synchroniser
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // capture a word; the shared pins carry its inverse
  task automatic capture(input count_t d);
    data_in = d;
    ext_data = ~d;
    settle();
    reg_clk_pin = 1'b1;
    settle();
    reg_clk_pin = 1'b0;
    settle();
  endtask

  // one counter clock pulse, long enough to be seen
  task automatic count_pulse();
    cnt_clk_pin = 1'b1;
    settle();
    cnt_clk_pin = 1'b0;
    settle();
  endtask

  task automatic test_reset();
    check("counter", cnt, 8'h00);
    check("holding", hold, 8'h00);
    check("carry", {7'h00, carry_n}, 8'h01);
    check("drive", {7'h00, pins_oe}, 8'h00);
  endtask

  task automatic test_load();
    capture(8'hA5);
    check("holding", hold, 8'hA5);
    check("counter", cnt, 8'h00);
    load_n = 1'b0;
    settle();
    check("counter", cnt, 8'hA5);
    capture(8'hFD);
    check("counter", cnt, 8'hFD);
    load_n = 1'b1;
    settle();
  endtask

  task automatic test_count();
    count_pulse();
    check("counter", cnt, 8'hFD);
    en_n = 1'b0;
    count_pulse();
    check("counter", cnt, 8'hFE);
    check("carry", {7'h00, carry_n}, 8'h01);
    count_pulse();
    check("counter", cnt, 8'hFF);
    check("carry", {7'h00, carry_n}, 8'h00);
    count_pulse();
    check("counter", cnt, 8'h00);
    check("carry", {7'h00, carry_n}, 8'h01);
  endtask

  task automatic test_clear();
    count_pulse();
    load_n = 1'b0;
    clr_n = 1'b0;
    settle();
    check("counter", cnt, 8'h00);
    load_n = 1'b1;
    count_pulse();
    check("counter", cnt, 8'h00);
    clr_n = 1'b1;
    settle();
    check("counter", cnt, 8'h00);
  endtask

  task automatic test_shared();
    mode = 1'b1;
    ext_oe = 1'b1;
    capture(8'hC3);
    check("holding", hold, 8'h3C);
    ext_oe = 1'b0;
    load_n = 1'b0;
    settle();
    load_n = 1'b1;
    // every enable pair; only high with low drives
    for (int i = 0; i < 4; i++)
    begin
      {oe, oe_n} = i[1:0];
      settle();
      check("drive", {7'h00, pins_oe}, (i == 2) ? 8'h01 : 8'h00);
    end
    {oe, oe_n} = 2'b10;
    settle();
    check("pins", pins_level, 8'h3C);
    count_pulse();
    check("pins", pins_level, 8'h3D);
  endtask

  // reset in mid-run while the pins are driven, then recovery
  task automatic test_mid_reset();
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    check("counter", cnt, 8'h00);
    check("holding", hold, 8'h00);
    check("carry", {7'h00, carry_n}, 8'h01);
    check("drive", {7'h00, pins_oe}, 8'h00);
    reset_n = 1'b1;
    @(negedge clk);
    check("drive", {7'h00, pins_oe}, 8'h00);
    settle();
    check("drive", {7'h00, pins_oe}, 8'h01);
    check("pins", pins_level, 8'h00);
  endtask

  // print the verdict and stop
  task automatic finish_test();
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // reset, then every scenario in turn
  initial
  begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    test_reset();
    test_load();
    test_count();
    test_clear();
    test_shared();
    test_mid_reset();
    finish_test();
  end
endmodule // loadable_counter_with_input_register_tb_top
